// >>> src/fcm_consts.svh
`ifndef FCM_CONSTS_SVH
`define FCM_CONSTS_SVH

// ----------------------------------------
// register offsets (word index)
// ----------------------------------------
`define FCM_OFS_MASK1     8'h00
`define FCM_OFS_MASK2     8'h01
`define FCM_OFS_MASK3     8'h02
`define FCM_OFS_MASK4     8'h03
`define FCM_OFS_REACT     8'h04
`define FCM_OFS_LEVEL     8'h05
`define FCM_OFS_AIN_FUNC  8'h06
`define FCM_OFS_FREQ_CAP  8'h07
`define FCM_OFS_FAULT     8'h08
`define FCM_OFS_IRQ_STAT  8'h09
`define FCM_OFS_IRQ_EN    8'h0a
`define FCM_OFS_IRQ_CLR   8'h0b

// ----------------------------------------
// reset values
// ----------------------------------------
`define FCM_RST_MASK      16'h0000
`define FCM_RST_REACT     2'h0
`define FCM_RST_LEVEL     10'h1f4
`define FCM_RST_AIN_FUNC  4'h0

// ----------------------------------------
// field positions and limits
// ----------------------------------------
`define FCM_CAT_CURRENT   0
`define FCM_CAT_VOLTAGE   1
`define FCM_CAT_OVERLOAD  2
`define FCM_CAT_SYSTEM    3
`define FCM_CAT_FEEDBACK  4
`define FCM_CAT_EXTERNAL  5
`define FCM_CAT_COMM      6
`define FCM_FUNC_PTC      4'h6
`define FCM_LEVEL_MAX     10'h3e8
`define FCM_ADC_MAX       12'hfff
`define FCM_IRQ_FAULT     0
`define FCM_IRQ_THERM     1
`define FCM_IRQ_CLEARED   2

`endif

// >>> src/fcm_pkg.sv
package fcm_pkg;

    // thermistor reaction choices
    typedef enum logic [1:0] {
        FCM_WARN_RUN   = 2'b00,
        FCM_WARN_RAMP  = 2'b01,
        FCM_WARN_COAST = 2'b10,
        FCM_NO_WARN    = 2'b11
    } fcm_react_t;

    // register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } fcm_bus_t;

    // complete module state
    typedef struct packed {
        logic [3:0][15:0] mask;
        fcm_react_t       react;
        logic [9:0]       level;
        logic [2:0][3:0]  ain_func;
        logic [15:0]      freq_cap;
        logic [7:0]       fault_code;
        logic [6:0]       fault_cat;
        logic             fault_active;
        logic             over;
        logic             warn;
        logic             ramp_req;
        logic             coast_req;
        logic [3:0]       mfo;
        logic [2:0]       irq_stat;
        logic [2:0]       irq_en;
        logic             irq;
        logic [15:0]      rdata;
    } fcm_state_t;

endpackage

// >>> src/fcm_mapper.sv
`timescale 1ns/10ps
`include "fcm_consts.svh"
// Behaviour
// - mask words take 0..65535 as bitmasks
// - masked category fault drives its terminal
// - codes 1,4,6,28,79,82 are current
// - codes 7..15 and 62 are voltage
// - listed heat/torque codes are overload
// - codes 31,33..37,52,76,78 are system
// - code 48 is feedback
// - codes 49..51 are external
// - listed communication codes are communication
// - reaction: run, ramp, coast, silent; default 0
// - level 0.0..100.0 percent, default 50.0
// - supervision only with input function 6
// - frequency command captured on each fault
// - classify code recorded at forced stop
// - four independent mask words and terminals

module fcm_mapper
    import fcm_pkg::*;
#(
    parameter int N_AIN = 3
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [15:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [15:0]       reg_rdata_out,
    input  wire logic              fault_stop_in,
    input  wire logic [7:0]        fault_code_in,
    input  wire logic              fault_reset_in,
    input  wire logic [15:0]       freq_cmd_in,
    input  wire logic [N_AIN-1:0][11:0] ain_value_in,
    output logic      [3:0]        mfo_out,
    output logic                   therm_warn_out,
    output logic                   therm_ramp_stop_out,
    output logic                   therm_coast_stop_out,
    output logic                   irq_out
);

    // ----------------------------------------
    // state and bus bundle
    // ----------------------------------------
    fcm_state_t s;
    fcm_state_t next_s;
    fcm_bus_t   bus;

    assign bus.addr  = reg_addr_in;
    assign bus.wdata = reg_wdata_in;
    assign bus.wr    = reg_wr_in;
    assign bus.rd    = reg_rd_in;

    // ----------------------------------------
    // fault code classification
    // ----------------------------------------
    function automatic logic [6:0] classify(
        input logic [7:0] code
    );
        logic [6:0] cat;
        cat = 7'h00;
        unique case (code)
            8'h01,  // 1
            8'h04,  // 4
            8'h06,  // 6
            8'h1c,  // 28
            8'h4f,  // 79
            8'h52:  // 82
                cat[`FCM_CAT_CURRENT] = 1'b1;
            8'h07,  // 7
            8'h08,  // 8
            8'h09,  // 9
            8'h0a,  // 10
            8'h0b,  // 11
            8'h0c,  // 12
            8'h0d,  // 13
            8'h0e,  // 14
            8'h0f,  // 15
            8'h3e:  // 62
                cat[`FCM_CAT_VOLTAGE] = 1'b1;
            8'h10,  // 16
            8'h15,  // 21
            8'h16,  // 22
            8'h17,  // 23
            8'h18,  // 24
            8'h1a,  // 26
            8'h1b,  // 27
            8'h57,  // 87
            8'h80,  // 128
            8'h81,  // 129
            8'h86,  // 134
            8'h87:  // 135
                cat[`FCM_CAT_OVERLOAD] = 1'b1;
            8'h1f,  // 31
            8'h21,  // 33
            8'h22,  // 34
            8'h23,  // 35
            8'h24,  // 36
            8'h25,  // 37
            8'h34,  // 52
            8'h4c,  // 76
            8'h4e:  // 78
                cat[`FCM_CAT_SYSTEM] = 1'b1;
            8'h30:  // 48
                cat[`FCM_CAT_FEEDBACK] = 1'b1;
            8'h31,  // 49
            8'h32,  // 50
            8'h33:  // 51
                cat[`FCM_CAT_EXTERNAL] = 1'b1;
            8'h39,  // 57
            8'h3a,  // 58
            8'h66,  // 102
            8'h68,  // 104
            8'h69,  // 105
            8'h6a,  // 106
            8'h6b,  // 107
            8'h79,  // 121
            8'h7b,  // 123
            8'h7c,  // 124
            8'h7e:  // 126
                cat[`FCM_CAT_COMM] = 1'b1;
            default:
                cat = 7'h00;
        endcase
        return cat;
    endfunction

    // ----------------------------------------
    // thermistor comparison per analog input
    // ----------------------------------------
    logic [N_AIN-1:0] ain_is_ptc;
    logic [N_AIN-1:0] ain_over;
    logic [21:0]      level_scaled;

    // 100 % maps to the full-scale count
    assign level_scaled = 22'(s.level) * 22'(`FCM_ADC_MAX);

    genvar gi;
    generate
        for (gi = 0; gi < N_AIN; gi++) begin : g_ain
            assign ain_is_ptc[gi] =
                (s.ain_func[gi] == `FCM_FUNC_PTC);
            assign ain_over[gi] = ain_is_ptc[gi] &&
                (22'(ain_value_in[gi]) * 22'd1000 >
                 level_scaled);
        end
    endgenerate

    // ----------------------------------------
    // derived events
    // ----------------------------------------
    logic       over_now;
    logic       over_rise;
    logic [6:0] cat_now;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    assign over_now  = |ain_over;
    assign over_rise = over_now & ~s.over;
    assign cat_now   = classify(fault_code_in);

    // clear strobe from the write-only register
    assign irq_clr = (bus.wr &&
                      bus.addr == `FCM_OFS_IRQ_CLR) ?
                     bus.wdata[2:0] : 3'h0;

    // ----------------------------------------
    // sticky status, one cell per event
    // ----------------------------------------
    logic [2:0] next_stat;

    genvar gb;
    generate
        for (gb = 0; gb < 3; gb++) begin : g_stat
            // a set in the clear cycle wins, no event is lost
            assign next_stat[gb] = irq_set[gb] |
                (s.irq_stat[gb] & ~irq_clr[gb]);
        end
    endgenerate

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_s = s;

        // register writes
        if (bus.wr) begin
            unique case (bus.addr)
                `FCM_OFS_MASK1: next_s.mask[0] = bus.wdata;
                `FCM_OFS_MASK2: next_s.mask[1] = bus.wdata;
                `FCM_OFS_MASK3: next_s.mask[2] = bus.wdata;
                `FCM_OFS_MASK4: next_s.mask[3] = bus.wdata;
                `FCM_OFS_REACT:
                    next_s.react = fcm_react_t'(bus.wdata[1:0]);
                `FCM_OFS_LEVEL: begin
                    if (bus.wdata > 16'(`FCM_LEVEL_MAX)) begin
                        next_s.level = `FCM_LEVEL_MAX;
                    end else begin
                        next_s.level = bus.wdata[9:0];
                    end
                end
                `FCM_OFS_AIN_FUNC: begin
                    next_s.ain_func[0] = bus.wdata[3:0];
                    next_s.ain_func[1] = bus.wdata[7:4];
                    next_s.ain_func[2] = bus.wdata[11:8];
                end
                `FCM_OFS_IRQ_EN:
                    next_s.irq_en = bus.wdata[2:0];
                default: ;
            endcase
        end

        // operator reset drops the held fault
        if (fault_reset_in && s.fault_active) begin
            next_s.fault_active = 1'b0;
            next_s.fault_cat    = 7'h00;
        end
        if (fault_reset_in) begin
            next_s.ramp_req  = 1'b0;
            next_s.coast_req = 1'b0;
        end

        if (fault_stop_in) begin
            next_s.fault_active = 1'b1;
            next_s.fault_code   = fault_code_in;
            next_s.fault_cat    = cat_now;
            next_s.freq_cap     = freq_cmd_in;
        end

        next_s.over = over_now;
        next_s.warn = over_now &&
                      (s.react != FCM_NO_WARN);
        if (over_rise) begin
            unique case (s.react)
                FCM_WARN_RAMP:  next_s.ramp_req  = 1'b1;
                FCM_WARN_COAST: next_s.coast_req = 1'b1;
                FCM_WARN_RUN,
                FCM_NO_WARN:    ;
            endcase
        end

        for (int t = 0; t < 4; t++) begin
            next_s.mfo[t] = next_s.fault_active &&
                |(next_s.fault_cat & next_s.mask[t][6:0]);
        end

        // sticky status; a set beats a clear
        next_s.irq_stat = next_stat;
        next_s.irq      = |(next_s.irq_stat & next_s.irq_en);

        // read data valid the cycle after the strobe
        next_s.rdata = 16'h0000;
        if (bus.rd) begin
            unique case (bus.addr)
                `FCM_OFS_MASK1:    next_s.rdata = s.mask[0];
                `FCM_OFS_MASK2:    next_s.rdata = s.mask[1];
                `FCM_OFS_MASK3:    next_s.rdata = s.mask[2];
                `FCM_OFS_MASK4:    next_s.rdata = s.mask[3];
                `FCM_OFS_REACT:
                    next_s.rdata = {14'h0, s.react};
                `FCM_OFS_LEVEL:
                    next_s.rdata = {6'h0, s.level};
                `FCM_OFS_AIN_FUNC:
                    next_s.rdata = {4'h0, s.ain_func[2],
                                    s.ain_func[1],
                                    s.ain_func[0]};
                `FCM_OFS_FREQ_CAP: next_s.rdata = s.freq_cap;
                `FCM_OFS_FAULT:
                    next_s.rdata = {s.fault_active,
                                    s.fault_cat,
                                    s.fault_code};
                `FCM_OFS_IRQ_STAT:
                    next_s.rdata = {13'h0, s.irq_stat};
                `FCM_OFS_IRQ_EN:
                    next_s.rdata = {13'h0, s.irq_en};
                default:           next_s.rdata = 16'h0000;
            endcase
        end
    end

    // interrupt sources
    assign irq_set[`FCM_IRQ_FAULT]   = fault_stop_in;
    assign irq_set[`FCM_IRQ_THERM]   = over_rise &&
                                       (s.react != FCM_NO_WARN);
    assign irq_set[`FCM_IRQ_CLEARED] = fault_reset_in &&
                                       s.fault_active;

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s              <= '0;
            s.mask[0]      <= `FCM_RST_MASK;
            s.mask[1]      <= `FCM_RST_MASK;
            s.mask[2]      <= `FCM_RST_MASK;
            s.mask[3]      <= `FCM_RST_MASK;
            s.react        <= fcm_react_t'(`FCM_RST_REACT);
            s.level        <= `FCM_RST_LEVEL;
            s.ain_func[0]  <= `FCM_RST_AIN_FUNC;
            s.ain_func[1]  <= `FCM_RST_AIN_FUNC;
            s.ain_func[2]  <= `FCM_RST_AIN_FUNC;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // outputs straight from flops
    // ----------------------------------------
    assign reg_rdata_out        = s.rdata;
    assign mfo_out              = s.mfo;
    assign therm_warn_out       = s.warn;
    assign therm_ramp_stop_out  = s.ramp_req;
    assign therm_coast_stop_out = s.coast_req;
    assign irq_out              = s.irq;

endmodule

// >>> verif/fcm_tb_pkg.sv
package fcm_tb_pkg;

    function automatic logic [6:0] fcm_cat(input int c);
        case (c) inside
            1, 4, 6, 28, 79, 82:                  return 7'h01;
            [7:15], 62:                           return 7'h02;
            16, [21:24], 26, 27, 87, 128, 129,
            134, 135:                             return 7'h04;
            31, [33:37], 52, 76, 78:              return 7'h08;
            48:                                   return 7'h10;
            [49:51]:                              return 7'h20;
            57, 58, 102, [104:107], 121, 123,
            124, 126:                             return 7'h40;
            default:                              return 7'h00;
        endcase
    endfunction

    function automatic logic [3:0] fcm_term(input logic [3:0][15:0] m,
                                            input logic [6:0]       c);
        for (int t = 0; t < 4; t++) begin
            fcm_term[t] = |(m[t][6:0] & c);
        end
    endfunction

endpackage

// >>> verif/fcm_sva.sv
`timescale 1ns/10ps
module fcm_sva
    import fcm_tb_pkg::*;
#(
    parameter int N_AIN = 3
) (
    input wire logic                  clk_in,
    input wire logic                  rst_n_in,
    input wire logic [7:0]            reg_addr_in,
    input wire logic [15:0]           reg_wdata_in,
    input wire logic                  reg_wr_in,
    input wire logic                  reg_rd_in,
    input wire logic [15:0]           reg_rdata_out,
    input wire logic                  fault_stop_in,
    input wire logic [7:0]            fault_code_in,
    input wire logic                  fault_reset_in,
    input wire logic [15:0]           freq_cmd_in,
    input wire logic [N_AIN-1:0][11:0] ain_value_in,
    input wire logic [3:0]            mfo_out,
    input wire logic                  therm_warn_out,
    input wire logic                  therm_ramp_stop_out,
    input wire logic                  therm_coast_stop_out,
    input wire logic                  irq_out
);
    logic [3:0][15:0] mk;
    logic [2:0]       en;
    logic [1:0]       rc;
    logic [9:0]       lv;
    logic [11:0]      fn;
    logic [15:0]      cap;
    logic             ov;

    // shadow of settings, level clamps at full scale
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mk  <= '0;
            rc  <= 2'h0;
            lv  <= 10'h1f4;
            fn  <= 12'h000;
            cap <= 16'h0000;
            en  <= 3'h0;
        end else begin
            if (fault_stop_in)
                cap <= freq_cmd_in;
            if (reg_wr_in) begin
                case (reg_addr_in)
                    8'h00, 8'h01, 8'h02, 8'h03:
                        mk[reg_addr_in[1:0]] <= reg_wdata_in;
                    8'h04: rc <= reg_wdata_in[1:0];
                    8'h05: lv <= (reg_wdata_in > 16'd1000) ?
                                 10'd1000 : reg_wdata_in[9:0];
                    8'h06: fn <= reg_wdata_in[11:0];
                    8'h0a: en <= reg_wdata_in[2:0];
                    default: ;
                endcase
            end
        end
    end

    // over level only on inputs set to thermistor function
    always_comb begin
        ov = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (i < N_AIN && fn[i*4 +: 4] == 4'h6 &&
                {20'h0, ain_value_in[i]} * 32'd1000 > {22'h0, lv} * 32'd4095)
                ov = 1'b1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_rise;
        $rose(ov);
    endsequence

    AST_RD_IDLE: assert property (
        !reg_rd_in |=> reg_rdata_out == 16'h0)
        else $error("read data not idle");
    AST_MAP: assert property (
        fault_stop_in && !reg_wr_in |=>
            mfo_out == fcm_term(mk, fcm_cat($past(fault_code_in))))
        else $error("terminals disagree with fault category");
    AST_CLR: assert property (
        fault_reset_in && !fault_stop_in |=> mfo_out == 4'h0)
        else $error("terminals kept after fault reset");
    AST_CAP: assert property (
        reg_rd_in && reg_addr_in == 8'h07 && !fault_stop_in |=>
            reg_rdata_out == cap)
        else $error("captured frequency wrong");
    AST_WARN: assert property (
        ov && rc != 2'h3 |=> therm_warn_out)
        else $error("warning missing over level");
    AST_SILENT: assert property (
        !ov || rc == 2'h3 |=> !therm_warn_out)
        else $error("warning without cause");
    AST_RAMP: assert property (
        s_rise ##0 rc == 2'h1 |=> therm_ramp_stop_out)
        else $error("ramp stop missing");
    AST_COAST: assert property (
        s_rise ##0 rc == 2'h2 |=> therm_coast_stop_out)
        else $error("coast stop missing");
    AST_LATCH: assert property (
        therm_ramp_stop_out && !fault_reset_in |=> therm_ramp_stop_out)
        else $error("ramp stop dropped early");
    AST_COAST_HOLD: assert property (
        therm_coast_stop_out && !fault_reset_in |=> therm_coast_stop_out)
        else $error("coast stop dropped early");
    AST_IRQ: assert property (
        fault_stop_in && en[0] && !reg_wr_in |=> irq_out)
        else $error("fault interrupt missing");
endmodule

bind fcm_mapper fcm_sva #(.N_AIN(N_AIN)) u_sva (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .reg_addr_in          (reg_addr_in),
    .reg_wdata_in         (reg_wdata_in),
    .reg_wr_in            (reg_wr_in),
    .reg_rd_in            (reg_rd_in),
    .reg_rdata_out        (reg_rdata_out),
    .fault_stop_in        (fault_stop_in),
    .fault_code_in        (fault_code_in),
    .fault_reset_in       (fault_reset_in),
    .freq_cmd_in          (freq_cmd_in),
    .ain_value_in         (ain_value_in),
    .mfo_out              (mfo_out),
    .therm_warn_out       (therm_warn_out),
    .therm_ramp_stop_out  (therm_ramp_stop_out),
    .therm_coast_stop_out (therm_coast_stop_out),
    .irq_out              (irq_out)
);

// >>> verif/fcm_far.sv
`timescale 1ns/10ps
module fcm_far (
    input  wire logic             clk_in,
    output logic                  stop_out,
    output logic [7:0]            code_out,
    output logic                  reset_out,
    output logic [15:0]           freq_out,
    output logic [2:0][11:0]      ain_out
);
    // idle levels before any event
    initial begin
        stop_out = 1'b0;
        code_out = 8'h00;
        reset_out = 1'b0;
        freq_out = 16'h0000;
        ain_out = '0;
    end

    task fault(input logic [7:0] c, input logic [15:0] f);
        @(posedge clk_in);
        stop_out <= 1'b1;
        code_out <= c;
        freq_out <= f;
        @(posedge clk_in);
        stop_out <= 1'b0;
        code_out <= ~c;  // record no longer held, show junk
        freq_out <= ~f;
    endtask

    // operator reset pulse
    task clear();
        @(posedge clk_in);
        reset_out <= 1'b1;
        @(posedge clk_in);
        reset_out <= 1'b0;
    endtask

    // new analog level, returns once taken
    task sense(input int i, input logic [11:0] v);
        @(posedge clk_in);
        ain_out[i] <= v;
        @(posedge clk_in);
    endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
    import fcm_tb_pkg::*;
    logic             clk_in;
    logic             rst_n_in;
    logic [7:0]       reg_addr_in;
    logic [15:0]      reg_wdata_in;
    logic             reg_wr_in;
    logic             reg_rd_in;
    logic [15:0]      reg_rdata_out;
    logic             stop;
    logic [7:0]       code;
    logic             freset;
    logic [15:0]      freq;
    logic [2:0][11:0] ain;
    logic [3:0]       mfo_out;
    logic             warn;
    logic             ramp;
    logic             coast;
    logic             irq;
    logic [3:0][15:0] m;
    logic [15:0]      f;
    int               error_cnt;
    int               tests_run;
    int               seed;
    int               cyc;
    int               lv;
    int               thr;

    fcm_mapper dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .fault_stop_in(stop),
        .fault_code_in(code), .fault_reset_in(freset),
        .freq_cmd_in(freq), .ain_value_in(ain), .mfo_out(mfo_out),
        .therm_warn_out(warn), .therm_ramp_stop_out(ramp),
        .therm_coast_stop_out(coast), .irq_out(irq));
    fcm_far far (.clk_in(clk_in), .stop_out(stop), .code_out(code),
        .reset_out(freset), .freq_out(freq), .ain_out(ain));

    // 50 MHz clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("mismatch %0t timeout", $time);
            final_report();
        end
    end

    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, e);
    endtask
    task final_report();
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        seed = 90485;
        error_cnt = 0;
        tests_run = 0;
        cyc = 0;
        rst_n_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 16'h0000;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        for (int a = 0; a < 16; a++) begin
            rd(a[7:0], a == 5 ? 16'h01f4 : 16'h0);
        end
        for (int t = 0; t < 4; t++) begin
            m[t] = 16'($random(seed));
            wr(t[7:0], m[t]);
            rd(t[7:0], m[t]);
        end
        wr(8'h05, 16'h03e9);
        rd(8'h05, 16'h03e8);
        wr(8'h07, 16'h1234);
        rd(8'h07, 16'h0000);
        // single-bit masks isolate every category
        for (int p = 0; p < 2; p++) begin
            for (int t = 0; t < 4; t++) begin
                if (p == 0 || t < 3) m[t] = 16'h1 << (t + 4 * p);
                wr(t[7:0], m[t]);
            end
            for (int c = 0; c < 150; c++) begin
                f = 16'({$random(seed)} % 15001);
                far.fault(c[7:0], f);
                #1 chk(16'(mfo_out), 16'(fcm_term(m, fcm_cat(c))));
                rd(8'h07, f);
                rd(8'h08, {1'b1, fcm_cat(c), c[7:0]});
            end
        end
        far.clear();
        #1 chk(16'(mfo_out), 16'h0);
        // interrupt raise, mask, clear
        wr(8'h0a, 16'h0007);
        wr(8'h0b, 16'h0007);
        far.fault(8'd48, 16'd0);
        @(posedge clk_in) #1 chk(16'(irq), 16'h1);
        rd(8'h09, 16'h0001);
        wr(8'h0a, 16'h0002);
        @(posedge clk_in) #1 chk(16'(irq), 16'h0);
        wr(8'h0b, 16'h0001);
        rd(8'h09, 16'h0000);
        // thermistor: off without function, then each reaction
        lv = {$random(seed)} % 1000;
        thr = lv * 4095 / 1000;
        wr(8'h05, lv[15:0]);
        far.sense(1, 12'hfff);
        far.sense(0, 12'hfff);
        #1 chk(16'(warn), 16'h0);
        far.sense(0, 12'h000);
        wr(8'h06, 16'h0006);
        for (int r = 0; r < 4; r++) begin
            wr(8'h04, r[15:0]);
            far.sense(0, thr[11:0]);
            #1 chk(16'(warn), 16'h0);
            far.sense(0, 12'(thr + 1));
            #1 chk(16'({warn, ramp, coast}),
                   16'({r != 3, r == 1, r == 2}));
            far.sense(0, 12'h000);
            far.clear();
            #1 chk(16'({ramp, coast}), 16'h0);
        end
        @(posedge clk_in) #1 chk(16'(irq), 16'h1);
        // mid-run reset: defaults back, every output low
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1 chk(16'({mfo_out, warn, ramp, coast, irq}), 16'h0);
        rd(8'h05, 16'h01f4);
        rd(8'h04, 16'h0000);
        final_report();
    end
endmodule
